/* File: rtl/ldb_pkg.sv */
/*
 * Constants and types for the link demo button and LED controller.
 * Assumes a 250 MHz system clock; all timing is kept in milliseconds.
 */
package ldb_pkg;
	// Clock and millisecond tick
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned TICK_NS       = 1000000;
	localparam int unsigned TICK_CYC      = TICK_NS / CLK_PERIOD_NS;

	// Millisecond figures
	localparam logic [14:0] DEBOUNCE_MS   = 15'h0014; // 20 ms
	localparam logic [14:0] ROLE_HOLD_MS  = 15'h05dc; // 1.5 s
	localparam logic [14:0] MENU_HOLD_MS  = 15'h07d0; // 2 s
	localparam logic [14:0] LINK_FLASH_MS = 15'h07d0; // 2 s
	localparam logic [14:0] ASSOC_MS      = 15'h7530; // 30 s
	localparam logic [14:0] BLINK_MS      = 15'h0032; // Fast blink half period
	localparam logic [14:0] SHOW_MS       = 15'h0064; // Signal strength flash
	localparam logic [14:0] FLASH_MS      = 15'h00c8; // Channel count half period
	localparam logic [14:0] MS_MAX        = 15'h7fff;

	// Pin levels of the active low LEDs and button
	localparam logic LED_ON  = 1'b0;
	localparam logic LED_OFF = 1'b1;

	// Control states, Gray coded along the usual path
	typedef enum logic [2:0] {
		ST_ROLE   = 3'h0,
		ST_ASSOC  = 3'h1,
		ST_PING   = 3'h3,
		ST_MENU   = 3'h2,
		ST_ACCEPT = 3'h6,
		ST_DEAD   = 3'h4
	} ldb_state_e;

	// Events from the radio logic
	typedef struct packed {
		logic       link_up;  // Peer link made
		logic       rx_event; // Packet or acknowledgement received
		logic [1:0] rssi;     // 0 none, 1 marginal, 2 good, 3 excellent
	} ldb_radio_s;

	// LED lit flags
	typedef struct packed {
		logic red;
		logic yellow;
		logic green;
	} ldb_led_s;
endpackage

/* File: rtl/ldb_ctrl.sv */
/*
 * Link demo controller: role pick, association, ping-pong display, channel menu.
 * Assumes radio events arrive on clk_sys_in and the button pin is asynchronous.
 */
// What this block does
// (R01) Button pin is active low and starts the demonstration.
// (R02) LED pins are driven low to light, high to go dark.
// (R03) Button held past hold period after reset lights green; release then picks master.
// (R04) Release within 1.5 s of reset picks slave.
// (R05) Red flashes fast during association until linked.
// (R06) On link, red off and green flashes fast about two seconds.
// (R07) Association ends thirty seconds after reset; linked goes to ping-pong.
// (R08) Unlinked at timeout stays silent until reset.
// (R09) Ping-pong flashes LEDs once per received packet or acknowledgement.
// (R10) Red and green encode strength: none, marginal, good, excellent.
// (R11) Channel menu only reachable from ping-pong.
// (R12) Two second hold in ping-pong enters menu, yellow lit steady.
// (R13) On release in menu, red flashes the channel number one to four.
// (R14) Each short press increments channel and flashes the new number.
// (R15) Two second hold accepts, green goes out; release returns to ping-pong.
// (R16) Button is debounced; hold times use a millisecond timer.
// (R17) Channel number wraps from four back to one.
`timescale 1ns/1ps
`default_nettype none

module ldb_ctrl #(
	parameter int unsigned TICK_CYC = ldb_pkg::TICK_CYC
) (
	input  wire logic              clk_sys_in,
	input  wire logic              rst_in,
	input  wire logic              user_button_in,
	input  wire ldb_pkg::ldb_radio_s radio_in,
	output logic                   green_indicator_out,
	output logic                   yellow_indicator_out,
	output logic                   red_indicator_out,
	output logic                   role_master_out,
	output logic                   comm_enable_out,
	output logic [1:0]             channel_out,
	output logic                   channel_accept_out
);
	ldb_pkg::ldb_state_e state;
	ldb_pkg::ldb_state_e next_state;
	ldb_pkg::ldb_led_s   next_led;
	logic [17:0] tick_cnt;
	logic        tick;
	logic [2:0]  btn_sync;
	logic        pressed;
	logic [14:0] db_ms;
	logic        agree;
	logic        btn_flip;
	logic        rel_ev;
	logic [14:0] hold_ms;
	logic        hold_step;
	logic        long_hit;
	logic [14:0] up_ms;
	logic        assoc_end;
	logic [14:0] blink_ms;
	logic        blink;
	logic        linked;
	logic [14:0] lflash_ms;
	logic [14:0] show_ms;
	logic [1:0]  rssi_q;
	logic        first_rel;
	logic        menu_show;
	logic        incr;
	logic [2:0]  flashes;
	logic [14:0] fl_ms;
	logic        fl_on;
	logic        fl_end;

	// Millisecond tick from the system clock
	assign tick = (tick_cnt == 18'(TICK_CYC - 1));
	always_ff @(posedge clk_sys_in) begin
		tick_cnt <= (rst_in || tick) ? 18'h0 : tick_cnt + 18'h1;
	end

	// Button: three-stage sync, change counts when stages two and three agree
	assign agree    = (btn_sync[1] == btn_sync[2]) && ((!btn_sync[2]) != pressed); // R01
	assign btn_flip = agree && tick && (db_ms == ldb_pkg::DEBOUNCE_MS - 15'h1);      // R16
	assign rel_ev   = btn_flip && pressed;
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			btn_sync <= 3'h0; // Button taken as held at reset
			pressed  <= 1'b1;
			db_ms    <= 15'h0;
		end else begin
			btn_sync <= {btn_sync[1:0], user_button_in};
			pressed  <= pressed ^ btn_flip;
			db_ms    <= (!agree || btn_flip) ? 15'h0 : db_ms + {14'h0, tick}; // R16
		end
	end

	// Hold timer and uptime since reset
	assign hold_step = pressed && tick && (hold_ms != ldb_pkg::MS_MAX);
	assign long_hit  = hold_step && (hold_ms == ldb_pkg::MENU_HOLD_MS - 15'h1); // R12
	assign assoc_end = tick && (up_ms >= ldb_pkg::ASSOC_MS - 15'h1);            // R07
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			hold_ms <= 15'h0;
			up_ms   <= 15'h0;
		end else begin
			hold_ms <= !pressed ? 15'h0 : hold_ms + {14'h0, hold_step}; // R16
			up_ms   <= up_ms + {14'h0, tick && (up_ms != ldb_pkg::ASSOC_MS)};
		end
	end

	// Fast blink phase for association display
	always_ff @(posedge clk_sys_in) begin
		if (rst_in || (tick && blink_ms == ldb_pkg::BLINK_MS - 15'h1)) begin
			blink_ms <= 15'h0;
			blink    <= rst_in ? 1'b1 : !blink;
		end else begin
			blink_ms <= blink_ms + {14'h0, tick};
		end
	end

	// Link flag and the two second green flash after linking
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			linked    <= 1'b0;
			lflash_ms <= 15'h0;
		end else if (state == ldb_pkg::ST_ASSOC && radio_in.link_up && !linked) begin
			linked    <= 1'b1;
			lflash_ms <= ldb_pkg::LINK_FLASH_MS; // R06
		end else begin
			lflash_ms <= lflash_ms - {14'h0, tick && lflash_ms != 15'h0};
		end
	end

	// Signal strength capture, one flash per received frame
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			show_ms <= 15'h0;
			rssi_q  <= 2'h0;
		end else if (state == ldb_pkg::ST_PING && radio_in.rx_event) begin
			show_ms <= ldb_pkg::SHOW_MS; // R09
			rssi_q  <= radio_in.rssi;
		end else begin
			show_ms <= show_ms - {14'h0, tick && show_ms != 15'h0};
		end
	end

	// Menu release handling: first release shows, later ones increment
	assign menu_show = (state == ldb_pkg::ST_MENU) && rel_ev;              // R13
	assign incr      = menu_show && !first_rel;                            // R14
	assign fl_end    = tick && (fl_ms == ldb_pkg::FLASH_MS - 15'h1);
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			channel_out <= 2'h0;
			first_rel   <= 1'b0;
		end else begin
			channel_out <= channel_out + {1'b0, incr}; // R17
			first_rel   <= (state == ldb_pkg::ST_PING) ? 1'b1 : (first_rel && !menu_show);
		end
	end

	// Red flash counter for the channel number
	always_ff @(posedge clk_sys_in) begin
		if (rst_in || state != ldb_pkg::ST_MENU || long_hit) begin
			flashes <= 3'h0;
			fl_ms   <= 15'h0;
			fl_on   <= 1'b0;
		end else if (menu_show) begin
			flashes <= {1'b0, channel_out + {1'b0, incr}} + 3'h1; // R13 R14
			fl_ms   <= 15'h0;
			fl_on   <= 1'b1;
		end else if (fl_end && flashes != 3'h0) begin
			fl_ms   <= 15'h0;
			fl_on   <= !fl_on && (flashes != 3'h1);
			flashes <= flashes - {2'h0, !fl_on};
		end else begin
			fl_ms   <= fl_ms + {14'h0, tick};
		end
	end

	// State sequencing
	always_comb begin
		next_state = state;
		case (state)
			ldb_pkg::ST_ROLE: begin
				if (rel_ev) next_state = ldb_pkg::ST_ASSOC; // R03 R04
			end
			ldb_pkg::ST_ASSOC: begin
				if (assoc_end) next_state = linked ? ldb_pkg::ST_PING : ldb_pkg::ST_DEAD; // R07 R08
			end
			ldb_pkg::ST_PING: begin
				if (long_hit) next_state = ldb_pkg::ST_MENU; // R11 R12
			end
			ldb_pkg::ST_MENU: begin
				if (long_hit) next_state = ldb_pkg::ST_ACCEPT; // R15
			end
			ldb_pkg::ST_ACCEPT: begin
				if (rel_ev) next_state = ldb_pkg::ST_PING; // R15
			end
			ldb_pkg::ST_DEAD: next_state = ldb_pkg::ST_DEAD; // R08
			default: next_state = ldb_pkg::ST_ROLE;
		endcase
	end

	// LED lit pattern for each state
	always_comb begin
		next_led = '0;
		case (state)
			ldb_pkg::ST_ROLE: next_led.green = (hold_ms >= ldb_pkg::ROLE_HOLD_MS); // R03
			ldb_pkg::ST_ASSOC: begin
				next_led.red   = !linked && blink;                         // R05
				next_led.green = linked && blink && (lflash_ms != 15'h0); // R06
			end
			ldb_pkg::ST_PING: begin
				next_led.red   = (show_ms != 15'h0) && rssi_q[0]; // R09 R10
				next_led.green = (show_ms != 15'h0) && rssi_q[1]; // R10
			end
			ldb_pkg::ST_MENU: begin
				next_led.yellow = 1'b1; // R12
				next_led.green  = 1'b1;
				next_led.red    = fl_on && (flashes != 3'h0); // R13
			end
			ldb_pkg::ST_ACCEPT: next_led.yellow = 1'b1; // R15
			default: next_led = '0;
		endcase
	end

	// Registered state and pins; an LED lights by pulling its pin low
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			state                <= ldb_pkg::ST_ROLE;
			red_indicator_out    <= ldb_pkg::LED_OFF;
			yellow_indicator_out <= ldb_pkg::LED_OFF;
			green_indicator_out  <= ldb_pkg::LED_OFF;
			role_master_out      <= 1'b0;
			comm_enable_out      <= 1'b0;
			channel_accept_out   <= 1'b0;
		end else begin
			state                <= next_state;
			red_indicator_out    <= !next_led.red;    // R02
			yellow_indicator_out <= !next_led.yellow; // R02
			green_indicator_out  <= !next_led.green;  // R02
			if (state == ldb_pkg::ST_ROLE && rel_ev)
				role_master_out <= (hold_ms >= ldb_pkg::ROLE_HOLD_MS); // R03 R04
			comm_enable_out      <= (next_state != ldb_pkg::ST_DEAD) &&
			                        (next_state != ldb_pkg::ST_ROLE); // R08
			channel_accept_out   <= (state == ldb_pkg::ST_ACCEPT) && rel_ev;
		end
	end

	// Checks
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	property p_led_active_low;
		(state == ldb_pkg::ST_MENU) |=> (yellow_indicator_out == ldb_pkg::LED_ON);
	endproperty
	a_led_active_low: assert property (p_led_active_low) else $error("yellow not low"); // R02
	property p_master_pick;
		(state == ldb_pkg::ST_ROLE && rel_ev && hold_ms >= ldb_pkg::ROLE_HOLD_MS)
			|=> role_master_out && state == ldb_pkg::ST_ASSOC;
	endproperty
	a_master_pick: assert property (p_master_pick) else $error("master not picked"); // R03
	property p_slave_pick;
		(state == ldb_pkg::ST_ROLE && rel_ev && hold_ms < ldb_pkg::ROLE_HOLD_MS)
			|=> !role_master_out;
	endproperty
	a_slave_pick: assert property (p_slave_pick) else $error("slave not picked"); // R04
	property p_linked_red_off;
		(state == ldb_pkg::ST_ASSOC && linked) |=> red_indicator_out == ldb_pkg::LED_OFF;
	endproperty
	a_linked_red_off: assert property (p_linked_red_off) else $error("red lit after link"); // R06
	property p_assoc_end;
		(state == ldb_pkg::ST_ASSOC && assoc_end && linked) |=> state == ldb_pkg::ST_PING;
	endproperty
	a_assoc_end: assert property (p_assoc_end) else $error("no ping-pong after timeout"); // R07
	property p_dead_stays;
		(state == ldb_pkg::ST_DEAD) |=> (state == ldb_pkg::ST_DEAD && !comm_enable_out) [*3];
	endproperty
	a_dead_stays: assert property (p_dead_stays) else $error("left silent state"); // R08
	property p_rssi_show;
		(state == ldb_pkg::ST_PING && radio_in.rx_event && radio_in.rssi == 2'h3 && !long_hit)
			|=> ##1 (red_indicator_out == ldb_pkg::LED_ON && green_indicator_out == ldb_pkg::LED_ON);
	endproperty
	a_rssi_show: assert property (p_rssi_show) else $error("strength not shown"); // R09 R10
	property p_menu_entry;
		(state == ldb_pkg::ST_MENU && $past(state) != ldb_pkg::ST_MENU)
			|-> $past(state) == ldb_pkg::ST_PING;
	endproperty
	a_menu_entry: assert property (p_menu_entry) else $error("menu not from ping-pong"); // R11
	property p_wrap;
		(incr && channel_out == 2'h3) |=> channel_out == 2'h0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("channel did not wrap"); // R17
	property p_accept_green;
		(state == ldb_pkg::ST_ACCEPT) |=> green_indicator_out == ldb_pkg::LED_OFF;
	endproperty
	a_accept_green: assert property (p_accept_green) else $error("green lit on accept"); // R15
	c_master: cover property (state == ldb_pkg::ST_ROLE && rel_ev && hold_ms >= ldb_pkg::ROLE_HOLD_MS);
	c_ping:   cover property (state == ldb_pkg::ST_ASSOC ##1 state == ldb_pkg::ST_PING);
	c_menu:   cover property (incr);
	c_accept: cover property (channel_accept_out);
endmodule // ldb_ctrl

`default_nettype wire

/* File: testbench/ldb_operator.sv */
/*
 * Operator model: one push button pulled up to the supply, closed to ground when pressed.
 * Assumes the bench calls its tasks from one process at a time.
 */
`timescale 1ns/1ps
`default_nettype none

module ldb_operator #(
	parameter int TICK_CYC = 4
) (
	input  wire logic clk_sys_in,
	output var logic  button_pin_out
);
	// Pull-up keeps the pin high while the button is open
	initial begin
		button_pin_out = 1'b1;
	end

	// Close the switch just after an edge
	task automatic press();
		@(posedge clk_sys_in);
		button_pin_out <= 1'b0;
	endtask

	// Open the switch just after an edge
	task automatic let_go();
		@(posedge clk_sys_in);
		button_pin_out <= 1'b1;
	endtask

	// Hold then let go; hold length picks role, menu step or bounce
	task automatic hold(input int ms);
		press();
		repeat (ms * TICK_CYC) @(posedge clk_sys_in);
		let_go();
	endtask
endmodule // ldb_operator

`default_nettype wire

/* File: testbench/test_ldb_ctrl.sv */
/*
 * Self-checking bench for the link demo controller, with the operator model on the button.
 * Assumes a 1 ms tick of one clock so both 30 s association phases fit the run.
 */
`timescale 1ns/1ps
`default_nettype none

module test_ldb_ctrl;
	localparam int TK = 1; // One clock per ms keeps two association phases in the budget
	logic                clk_sys_in;
	logic                rst_in;
	wire logic           user_button_in;
	ldb_pkg::ldb_radio_s radio_in;
	logic                green, yellow, red, master, comm, accept;
	logic [1:0]          chan;
	logic [1:0]          r;
	int                  n_fail, cmp_count, n;
	logic [1:0]          q_led[$];
	logic [1:0]          q_ch[$];

	ldb_ctrl #(.TICK_CYC(TK)) u_ldb_ctrl (
		.clk_sys_in(clk_sys_in), .rst_in(rst_in), .user_button_in(user_button_in),
		.radio_in(radio_in), .green_indicator_out(green), .yellow_indicator_out(yellow),
		.red_indicator_out(red), .role_master_out(master), .comm_enable_out(comm),
		.channel_out(chan), .channel_accept_out(accept)
	);
	ldb_operator #(.TICK_CYC(TK)) u_ldb_operator (
		.clk_sys_in(clk_sys_in), .button_pin_out(user_button_in)
	);

	// Clock, 4 ns period
	initial begin
		clk_sys_in = 1'b0;
		forever #2 clk_sys_in = ~clk_sys_in;
	end

	task automatic ms(input int m);
		repeat (m * TK) @(posedge clk_sys_in);
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic got);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic chk_num(input string what, input logic [3:0] exp, input logic [3:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic summarize();
		if (n_fail == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Reset for 4 cycles with the button already held; called on an edge
	task automatic do_reset();
		rst_in <= 1'b1;
		u_ldb_operator.press();
		repeat (3) @(posedge clk_sys_in);
		rst_in <= 1'b0;
	endtask

	// Count falling edges (lightings) of red or green over a span
	task automatic count(input logic sel, input int m);
		logic p;
		n = 0;
		p = sel ? green : red;
		repeat (m * TK) begin
			@(posedge clk_sys_in);
			if (p === 1'b1 && (sel ? green : red) === 1'b0) n++;
			p = sel ? green : red;
		end
	endtask

	// Strength flash two cycles after each taken receive event
	initial begin
		forever begin
			@(posedge clk_sys_in iff radio_in.rx_event === 1'b1);
			repeat (2) @(posedge clk_sys_in);
			#1 chk_num("strength leds", 4'(q_led.pop_front()), 4'({red, green}));
		end
	end

	// Accepted channel on the accept pulse
	initial begin
		forever begin
			@(posedge clk_sys_in iff accept === 1'b1);
			#1 chk_num("accepted channel", 4'(q_ch.pop_front()), 4'(chan));
		end
	end

	// Watchdog, about a fifth beyond the planned run of some 72000 clocks
	initial begin
		#340000;
		n_fail++;
		summarize();
	end

	initial begin
		rst_in = 1'b1;
		radio_in = '0;
		void'($urandom(32'h3cdd));
		// Slave pick: quick release
		do_reset();
		ms(500);
		u_ldb_operator.let_go();
		ms(40);
		chk_bit("role", 1'b0, master);
		chk_bit("comm enable", 1'b1, comm);
		// No link by the timeout: silent and dark until a new reset
		ms(29600);
		chk_bit("comm when silent", 1'b0, comm);
		chk_num("silent leds", 4'h7, 4'({red, yellow, green}));
		// Master pick: hold past the green light
		do_reset();
		ms(1400);
		chk_bit("green before hold", ldb_pkg::LED_OFF, green);
		ms(200);
		chk_bit("green after hold", ldb_pkg::LED_ON, green);
		u_ldb_operator.let_go();
		ms(40);
		chk_bit("role", 1'b1, master);
		// Association: red blinks, a long hold opens no menu
		u_ldb_operator.press();
		count(1'b0, 2200);
		chk_bit("red blinking", 1'b1, n >= 20);
		chk_bit("yellow in association", ldb_pkg::LED_OFF, yellow);
		u_ldb_operator.let_go();
		@(posedge clk_sys_in);
		radio_in.link_up <= 1'b1;
		ms(5);
		chk_bit("red after link", ldb_pkg::LED_OFF, red);
		count(1'b1, 1000);
		chk_bit("green blinking", 1'b1, n >= 8);
		ms(1500);
		count(1'b1, 500);
		chk_num("green after blink", 4'h0, 4'(n));
		ms(23300);
		chk_bit("comm in ping-pong", 1'b1, comm);
		// Ping-pong: every strength, then random ones
		for (int i = 0; i < 7; i++) begin
			r = (i < 4) ? 2'(i) : 2'($urandom % 4);
			@(posedge clk_sys_in);
			q_led.push_back({~r[0], ~r[1]}); // Red pin carries bit 0, green pin bit 1
			radio_in <= '{link_up: 1'b1, rx_event: 1'b1, rssi: r};
			@(posedge clk_sys_in);
			radio_in.rx_event <= 1'b0;
			ms(150);
			chk_num("leds after flash", 4'h3, 4'({red, green}));
		end
		// Menu entry and first count
		u_ldb_operator.hold(2100);
		chk_bit("yellow in menu", ldb_pkg::LED_ON, yellow);
		count(1'b0, 1000);
		chk_num("first count", 4'h1, 4'(n));
		u_ldb_operator.hold(10);
		ms(100);
		chk_num("channel after bounce", 4'h0, 4'(chan));
		// Short presses step the channel and wrap
		for (int i = 1; i < 5; i++) begin
			u_ldb_operator.hold(60);
			count(1'b0, (i % 4 + 1) * 400 + 200);
			chk_num("flash count", 4'(i % 4 + 1), 4'(n));
			chk_num("channel", 4'(i % 4), 4'(chan));
		end
		// Accept: green out, release returns to ping-pong
		u_ldb_operator.press();
		ms(2100);
		chk_bit("green at accept", ldb_pkg::LED_OFF, green);
		q_ch.push_back(2'h0);
		u_ldb_operator.let_go();
		ms(40);
		chk_num("accept pulses left", 4'h0, 4'(q_ch.size()));
		summarize();
	end
endmodule // test_ldb_ctrl

`default_nettype wire
